//--- design/pfs_pkg.sv
/*
 * Constants for the program flash self-programmer: control bit positions,
 * unlock pattern, latch block geometry, reset values and operation timing.
 * Assumes a 25 MHz core clock where one clock is one instruction cycle.
 */
// Overview of operation
// [RULE1] Software loads address pair, clears config select, sets program select, sets read start.
// [RULE2] The second instruction cycle after read start is consumed by the flash read.
// [RULE3] The read word appears in the data pair in the very next cycle.
// [RULE4] The data pair keeps the last word until another read or software write.
// [RULE5] Software places two no-operations after setting read start.
// [RULE6] Program flash reads succeed regardless of the code protection bit.
// [RULE7] Erase during execution is by whole rows only.
// [RULE8] Row erase: address, selects, erase and write enable, 55h then AAh, write start.
// [RULE9] Erase select reads as busy and clears when the row erase finishes.
// [RULE10] Two setup cycles follow write start; software places two no-operations there.
// [RULE11] A row erase halts instruction execution for about 2 ms; clocks keep running.
// [RULE12] After the stall, execution resumes at the third instruction after the set.
// [RULE13] A program write never erases anything by itself.
// [RULE14] One program operation writes at most 32 latches inside one aligned block.
// [RULE15] Every write latch returns to the erased pattern when a program write completes.
// [RULE16] With load-only set, an unlocked write only stores the data pair into one latch.
// [RULE17] With load-only clear, the last latch is loaded then the block is programmed.
// [RULE18] The whole latch block is programmed, loaded this time or not.
// [RULE19] The 2 ms stall happens only for the final programming, never for latch loads.
// [RULE20] Software keeps interrupts off between the unlock writes and write start.
// [RULE21] Software increments the address and reloads data between latch loads.
// [RULE22] Read start and write start are set by software only, cleared by hardware.
// [RULE23] Write start cannot set unless write enable is already set.
// [RULE24] No write or erase starts without 55h, then AAh, then write start.
// [RULE25] Reading the unlock register always returns zero.
// [RULE26] A write start not directly after the unlock pair re-arms the detector.
package pfs_pkg;

   // ----------------------------------------------------------------
   // Control byte layout
   // ----------------------------------------------------------------
   localparam int CTL_READ_START  = 0;
   localparam int CTL_WRITE_START = 1;
   localparam int CTL_WRITE_EN    = 2;
   localparam int CTL_ERASE_SEL   = 4;
   localparam int CTL_LOAD_ONLY   = 5;
   localparam int CTL_CFG_SEL     = 6;
   localparam int CTL_PROG_SEL    = 7;
   localparam logic [7:0] CTL_RESET = 8'h00;

   // ----------------------------------------------------------------
   // Unlock pattern and geometry
   // ----------------------------------------------------------------
   localparam logic [7:0]  UNLOCK_FIRST  = 8'h55;
   localparam logic [7:0]  UNLOCK_SECOND = 8'haa;
   localparam int          WORD_W        = 14;
   localparam int          ADDR_W        = 15;
   localparam int          LATCH_COUNT   = 32;
   localparam int          LATCH_IDX_W   = 5;
   localparam logic [13:0] ERASED_WORD   = 14'h3fff;
   localparam logic [7:0]  ADDR_RESET    = 8'h00;
   localparam logic [7:0]  DATA_RESET    = 8'h00;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int SETUP_CYCLES = 2;
   localparam int CLK_KHZ      = 25000;
   localparam int OP_TIME_US   = 2000;
   localparam int OP_CYCLES    = (OP_TIME_US * CLK_KHZ) / 1000;

endpackage

//--- design/pfs_latch_mem.sv
/*
 * Write latch buffer: one write port, one read port with registered data.
 * Loads the erased pattern on reset only, not at power-up. Read of an address written in
 * the same cycle returns the old word.
 */
`timescale 1ns/1ps
module pfs_latch_mem #(
   parameter int DEPTH = pfs_pkg::LATCH_COUNT,
   parameter int IDX_W = pfs_pkg::LATCH_IDX_W,
   parameter int WIDTH = pfs_pkg::WORD_W
) (
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             rst,
   // Write port
   input  wire logic             wr_en,
   input  wire logic [IDX_W-1:0] wr_idx,
   input  wire logic [WIDTH-1:0] wr_word,
   // Read port
   input  wire logic [IDX_W-1:0] rd_idx,
   output logic      [WIDTH-1:0] rd_word_q
);

   logic [WIDTH-1:0] mem_q [DEPTH];

   always_ff @(posedge clock) begin
      rd_word_q <= mem_q[rd_idx];
      if (rst) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= WIDTH'(pfs_pkg::ERASED_WORD);
         end
      end else if (wr_en) begin
         mem_q[wr_idx] <= wr_word;
      end
   end

endmodule

//--- design/pfs_self_programmer.sv
/*
 * Program flash self-programmer: read path, unlock-guarded row erase and
 * block programming through a latch buffer, with core stall and skip.
 * Assumes the core writes registers by one-cycle strobes, one clock per
 * instruction cycle, and a flash array with one cycle read latency.
 */
`timescale 1ns/1ps
module pfs_self_programmer #(
   parameter int OP_CYCLES = pfs_pkg::OP_CYCLES
) (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst,
   // Core register writes
   input  wire logic [7:0]  core_wdata,
   input  wire logic        addr_high_wr,
   input  wire logic        addr_low_wr,
   input  wire logic        data_high_wr,
   input  wire logic        data_low_wr,
   input  wire logic        control_wr,
   input  wire logic        unlock_wr,
   // Core register readback
   output logic [7:0]       nvm_address_high,
   output logic [7:0]       nvm_address_low,
   output logic [7:0]       nvm_data_high,
   output logic [7:0]       nvm_data_low,
   output logic [7:0]       nvm_control,
   output logic [7:0]       nvm_unlock_register,
   // Core pipeline control
   output logic             core_skip,
   output logic             core_stall,
   // Flash array
   output logic             flash_rd_en,
   output logic [14:0]      flash_addr,
   input  wire logic [13:0] flash_rd_data,
   output logic             flash_erase,
   output logic             flash_prog_we,
   output logic [13:0]      flash_prog_data
);

   localparam int TMR_W = $clog2(OP_CYCLES + 1);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {PFS_LOCKED, PFS_GOT_FIRST, PFS_ARMED} pfs_unlock_e;
   typedef enum logic [2:0] {
      PFS_IDLE, PFS_RD_FETCH, PFS_RD_TAKE, PFS_SETUP,
      PFS_DISPATCH, PFS_ERASE, PFS_SWEEP, PFS_PROG_WAIT
   } pfs_op_e;

   typedef struct packed {
      logic [7:0]              addr_hi;
      logic [7:0]              addr_lo;
      logic [5:0]              data_hi;
      logic [7:0]              data_lo;
      logic                    read_start;
      logic                    write_start;
      logic                    write_enable;
      logic                    erase_select;
      logic                    load_latches_only;
      logic                    config_space_select;
      logic                    program_memory_select;
      pfs_unlock_e             unlock;
      pfs_op_e                 op;
      logic [1:0]              setup_cnt;
      logic [TMR_W-1:0]        timer;
      logic [4:0]              sweep_idx;
      logic                    skip;
      logic                    stall;
      logic                    rd_en;
      logic [14:0]             faddr;
      logic                    erase;
      logic                    prog_we;
   } pfs_state_s;

   pfs_state_s s_q;
   pfs_state_s s_d;

   logic             lat_wr_en;
   logic [4:0]       lat_wr_idx;
   logic [13:0]      lat_wr_word;
   logic [4:0]       lat_rd_idx;
   logic [13:0]      lat_rd_word;

   function automatic logic [14:0] word_addr(input logic [7:0] hi, input logic [7:0] lo);
      return {hi[6:0], lo};
   endfunction

   function automatic logic [14:0] block_base(input logic [7:0] hi, input logic [7:0] lo);
      logic [14:0] a;
      a = word_addr(hi, lo);
      return {a[14:pfs_pkg::LATCH_IDX_W], 5'h00};
   endfunction

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d         = s_q;
      s_d.skip    = 1'b0;
      s_d.rd_en   = 1'b0;
      s_d.prog_we = 1'b0;
      lat_wr_en   = 1'b0;
      lat_wr_idx  = s_q.addr_lo[4:0];
      lat_wr_word = {s_q.data_hi, s_q.data_lo};
      lat_rd_idx  = s_q.sweep_idx;

      if (addr_high_wr) begin
         s_d.addr_hi = core_wdata;
      end
      if (addr_low_wr) begin
         s_d.addr_lo = core_wdata;
      end
      if (data_high_wr) begin
         s_d.data_hi = core_wdata[5:0]; // RULE4
      end
      if (data_low_wr) begin
         s_d.data_lo = core_wdata; // RULE4
      end

      // Unlock detector: any break in 55h, AAh, write start re-locks
      if (unlock_wr) begin
         if (core_wdata == pfs_pkg::UNLOCK_FIRST) begin
            s_d.unlock = PFS_GOT_FIRST; // RULE24
         end else if (core_wdata == pfs_pkg::UNLOCK_SECOND && s_q.unlock == PFS_GOT_FIRST) begin
            s_d.unlock = PFS_ARMED; // RULE24
         end else begin
            s_d.unlock = PFS_LOCKED;
         end
      end

      if (control_wr) begin
         // Start bits only set from software; zeros written to them are ignored
         s_d.write_enable          = core_wdata[pfs_pkg::CTL_WRITE_EN];
         s_d.load_latches_only     = core_wdata[pfs_pkg::CTL_LOAD_ONLY];
         s_d.config_space_select   = core_wdata[pfs_pkg::CTL_CFG_SEL];
         s_d.program_memory_select = core_wdata[pfs_pkg::CTL_PROG_SEL];
         if (s_q.op == PFS_IDLE) begin
            s_d.erase_select = core_wdata[pfs_pkg::CTL_ERASE_SEL];
         end
         s_d.unlock = PFS_LOCKED; // RULE26
         if (core_wdata[pfs_pkg::CTL_READ_START] && s_q.op == PFS_IDLE
             && s_q.program_memory_select && !s_q.config_space_select) begin
            s_d.read_start = 1'b1; // RULE22
            s_d.rd_en      = 1'b1;
            s_d.faddr      = word_addr(s_q.addr_hi, s_q.addr_lo);
            s_d.op         = PFS_RD_FETCH;
         end else if (core_wdata[pfs_pkg::CTL_WRITE_START] && s_q.op == PFS_IDLE
                      && s_q.write_enable && s_q.unlock == PFS_ARMED // RULE23 RULE24
                      && s_q.program_memory_select && !s_q.config_space_select) begin
            s_d.write_start = 1'b1; // RULE22
            s_d.setup_cnt   = 2'(pfs_pkg::SETUP_CYCLES - 1);
            s_d.op          = PFS_SETUP;
         end
      end

      case (s_q.op)
         PFS_IDLE: begin
         end
         // First instruction after the set executes while flash is read
         PFS_RD_FETCH: begin
            s_d.skip = 1'b1; // RULE2
            s_d.op   = PFS_RD_TAKE;
         end
         // Code protection does not gate this path at all
         PFS_RD_TAKE: begin
            s_d.data_hi    = flash_rd_data[13:8]; // RULE3 RULE6
            s_d.data_lo    = flash_rd_data[7:0]; // RULE3
            s_d.read_start = 1'b0; // RULE22
            s_d.op         = PFS_IDLE;
         end
         PFS_SETUP: begin
            if (s_q.setup_cnt == 2'd0) begin
               s_d.op = PFS_DISPATCH; // RULE10
            end else begin
               s_d.setup_cnt = s_q.setup_cnt - 2'd1;
            end
         end
         PFS_DISPATCH: begin
            if (s_q.erase_select) begin
               s_d.faddr = block_base(s_q.addr_hi, s_q.addr_lo); // RULE7
               s_d.erase = 1'b1;
               s_d.stall = 1'b1; // RULE11
               s_d.timer = TMR_W'(OP_CYCLES - 1);
               s_d.op    = PFS_ERASE;
            end else begin
               lat_wr_en = 1'b1; // RULE16 RULE17
               if (s_q.load_latches_only) begin
                  s_d.write_start = 1'b0; // RULE19
                  s_d.op          = PFS_IDLE;
               end else begin
                  s_d.stall     = 1'b1; // RULE19
                  s_d.sweep_idx = 5'h00;
                  s_d.op        = PFS_SWEEP;
               end
            end
         end
         PFS_ERASE: begin
            if (s_q.timer == '0) begin
               s_d.erase        = 1'b0;
               s_d.stall        = 1'b0; // RULE12
               s_d.erase_select = 1'b0; // RULE9
               s_d.write_start  = 1'b0; // RULE22
               s_d.op           = PFS_IDLE;
            end else begin
               s_d.timer = s_q.timer - TMR_W'(1);
            end
         end
         // Every latch goes out, then is put back to the erased pattern
         PFS_SWEEP: begin
            lat_wr_en   = 1'b1;
            lat_wr_idx  = s_q.sweep_idx;
            lat_wr_word = pfs_pkg::ERASED_WORD; // RULE15
            s_d.prog_we = 1'b1; // RULE18 RULE13
            s_d.faddr   = block_base(s_q.addr_hi, s_q.addr_lo) | 15'(s_q.sweep_idx); // RULE14
            if (s_q.sweep_idx == 5'(pfs_pkg::LATCH_COUNT - 1)) begin
               s_d.timer = TMR_W'(OP_CYCLES - 1);
               s_d.op    = PFS_PROG_WAIT;
            end else begin
               s_d.sweep_idx = s_q.sweep_idx + 5'd1;
            end
         end
         PFS_PROG_WAIT: begin
            if (s_q.timer == '0) begin
               s_d.stall       = 1'b0; // RULE12
               s_d.write_start = 1'b0; // RULE22
               s_d.op          = PFS_IDLE;
            end else begin
               s_d.timer = s_q.timer - TMR_W'(1);
            end
         end
         default: begin
            s_d.op = PFS_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         s_q                       <= '0;
         s_q.addr_hi               <= pfs_pkg::ADDR_RESET;
         s_q.addr_lo               <= pfs_pkg::ADDR_RESET;
         s_q.data_hi               <= pfs_pkg::DATA_RESET[5:0];
         s_q.data_lo               <= pfs_pkg::DATA_RESET;
         s_q.read_start            <= pfs_pkg::CTL_RESET[pfs_pkg::CTL_READ_START];
         s_q.write_start           <= pfs_pkg::CTL_RESET[pfs_pkg::CTL_WRITE_START];
         s_q.write_enable          <= pfs_pkg::CTL_RESET[pfs_pkg::CTL_WRITE_EN];
         s_q.erase_select          <= pfs_pkg::CTL_RESET[pfs_pkg::CTL_ERASE_SEL];
         s_q.load_latches_only     <= pfs_pkg::CTL_RESET[pfs_pkg::CTL_LOAD_ONLY];
         s_q.config_space_select   <= pfs_pkg::CTL_RESET[pfs_pkg::CTL_CFG_SEL];
         s_q.program_memory_select <= pfs_pkg::CTL_RESET[pfs_pkg::CTL_PROG_SEL];
         s_q.unlock                <= PFS_LOCKED;
         s_q.op                    <= PFS_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   pfs_latch_mem u_latches (
      .clock     (clock),
      .rst       (rst),
      .wr_en     (lat_wr_en),
      .wr_idx    (lat_wr_idx),
      .wr_word   (lat_wr_word),
      .rd_idx    (lat_rd_idx),
      .rd_word_q (lat_rd_word)
   );

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign nvm_address_high    = s_q.addr_hi;
   assign nvm_address_low     = s_q.addr_lo;
   assign nvm_data_high       = {2'b00, s_q.data_hi};
   assign nvm_data_low        = s_q.data_lo;
   assign nvm_control         = {s_q.program_memory_select, s_q.config_space_select,
                                 s_q.load_latches_only, s_q.erase_select, 1'b0,
                                 s_q.write_enable, s_q.write_start, s_q.read_start};
   assign nvm_unlock_register = 8'h00; // RULE25
   assign core_skip           = s_q.skip;
   assign core_stall          = s_q.stall;
   assign flash_rd_en         = s_q.rd_en;
   assign flash_addr          = s_q.faddr;
   assign flash_erase         = s_q.erase;
   assign flash_prog_we       = s_q.prog_we;
   assign flash_prog_data     = lat_rd_word;

endmodule

//--- tb/pfs_self_programmer_chk.sv
/*
 * Checker for the program flash self-programmer, bound to its top ports.
 * Assumes OP_CYCLES handed on by the bind and one clock per instruction.
 */
`timescale 1ns/1ps
module pfs_self_programmer_chk #(
   parameter int OP_CYCLES = pfs_pkg::OP_CYCLES
) (
   // Clock and reset
   input wire logic        clock,
   input wire logic        rst,
   // Core writes
   input wire logic [7:0]  core_wdata,
   input wire logic        data_high_wr,
   input wire logic        data_low_wr,
   input wire logic        control_wr,
   input wire logic        unlock_wr,
   // Readback and pipeline
   input wire logic [7:0]  nvm_data_high,
   input wire logic [7:0]  nvm_data_low,
   input wire logic [7:0]  nvm_control,
   input wire logic [7:0]  nvm_unlock_register,
   input wire logic        core_skip,
   input wire logic        core_stall,
   // Flash array
   input wire logic        flash_rd_en,
   input wire logic [14:0] flash_addr,
   input wire logic [13:0] flash_rd_data,
   input wire logic        flash_erase,
   input wire logic        flash_prog_we
);
   // ----
   // Helper state
   // ----
   logic [1:0]  arm_q;
   logic [15:0] erase_cnt_q;
   logic [7:0]  prog_cnt_q;
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // Own copy of the unlock detector, judged against start acceptance
   always_ff @(posedge clock) begin
      if (rst || control_wr) begin
         arm_q <= 2'h0;
      end else if (unlock_wr) begin
         arm_q <= (core_wdata == pfs_pkg::UNLOCK_FIRST) ? 2'h1 :
                  (core_wdata == pfs_pkg::UNLOCK_SECOND && arm_q == 2'h1) ? 2'h2 : 2'h0;
      end
   end
   always_ff @(posedge clock) begin
      erase_cnt_q <= (rst || !flash_erase) ? 16'h0000 : erase_cnt_q + 16'h0001;
      prog_cnt_q  <= (rst || !flash_prog_we) ? 8'h00 : prog_cnt_q + 8'h01;
   end
   // ----
   // Assertions
   // ----
   AST_UNLOCK_ZERO: assert property (nvm_unlock_register == 8'h00)
      else $error("unlock register read not zero");
   AST_READ_SKIP: assert property ($rose(nvm_control[0]) |-> flash_rd_en ##1 core_skip)
      else $error("read did not skip the second cycle");
   AST_READ_DATA: assert property (core_skip |=> nvm_data_low == $past(flash_rd_data[7:0])
      && nvm_data_high == {2'h0, $past(flash_rd_data[13:8])}) else $error("read word lost");
   AST_DATA_HOLD: assert property (!core_skip && !data_low_wr && !data_high_wr |=>
      $stable(nvm_data_low) && $stable(nvm_data_high)) else $error("data pair changed");
   AST_RD_CLEAR: assert property ($rose(nvm_control[0]) |-> ##2 !nvm_control[0])
      else $error("read start not cleared");
   AST_WS_WRITE_ENABLE: assert property ($rose(nvm_control[1]) |-> $past(nvm_control[2]))
      else $error("write start set without write enable");
   AST_WS_UNLOCK: assert property ($rose(nvm_control[1]) |-> $past(arm_q) == 2'h2)
      else $error("write start without unlock pair");
   AST_SETUP_STALL: assert property ($rose(nvm_control[1]) && !nvm_control[5] |->
      !core_stall [*3] ##1 core_stall) else $error("stall not after two setup cycles");
   AST_LOAD_NOSTALL: assert property ($rose(nvm_control[1]) && nvm_control[5] |->
      !core_stall [*3] ##1 (!core_stall && !nvm_control[1])) else $error("latch load wrong");
   AST_ERASE_LEN: assert property ($fell(flash_erase) |-> erase_cnt_q == OP_CYCLES)
      else $error("erase length wrong");
   AST_ERASE_ROW: assert property (flash_erase |-> core_stall && flash_addr[4:0] == 5'h00)
      else $error("erase not row aligned or no stall");
   AST_ERASE_DONE: assert property ($fell(flash_erase) |-> !nvm_control[4] && !nvm_control[1])
      else $error("erase status not cleared");
   AST_NO_AUTO_ERASE: assert property (!nvm_control[4] |-> !flash_erase)
      else $error("erase without erase select");
   AST_PROG_COUNT: assert property ($fell(flash_prog_we) |-> prog_cnt_q == 8'd32)
      else $error("block program length wrong");
   AST_PROG_ADDR: assert property (flash_prog_we |-> core_stall && (!$past(flash_prog_we) ?
      flash_addr[4:0] == 5'h00 : flash_addr == $past(flash_addr) + 15'h0001))
      else $error("program address sequence wrong");
   // ----
   // Covers
   // ----
   COV_READ:  cover property ($rose(nvm_control[0]) ##3 !nvm_control[0]);
   COV_ERASE: cover property ($fell(flash_erase));
   COV_PROG:  cover property ($fell(flash_prog_we));
   COV_LOAD:  cover property ($rose(nvm_control[1]) && nvm_control[5]);
endmodule

bind pfs_self_programmer pfs_self_programmer_chk #(.OP_CYCLES(OP_CYCLES)) chk (
   .clock(clock), .rst(rst), .core_wdata(core_wdata), .data_high_wr(data_high_wr),
   .data_low_wr(data_low_wr), .control_wr(control_wr), .unlock_wr(unlock_wr),
   .nvm_data_high(nvm_data_high), .nvm_data_low(nvm_data_low), .nvm_control(nvm_control),
   .nvm_unlock_register(nvm_unlock_register), .core_skip(core_skip), .core_stall(core_stall),
   .flash_rd_en(flash_rd_en), .flash_addr(flash_addr), .flash_rd_data(flash_rd_data),
   .flash_erase(flash_erase), .flash_prog_we(flash_prog_we));

//--- tb/pfs_flash_model.sv
/*
 * Behavioural flash array, 128 words mirrored over the address space.
 * Assumes one cycle read latency and row base on flash_addr while erasing.
 */
`timescale 1ns/1ps
module pfs_flash_model (
   // Clock
   input  wire logic        clock,
   // Array access
   input  wire logic        flash_rd_en,
   input  wire logic [14:0] flash_addr,
   output logic      [13:0] flash_rd_data,
   input  wire logic        flash_erase,
   input  wire logic        flash_prog_we,
   input  wire logic [13:0] flash_prog_data
);
   logic [13:0] mem [128];
   logic [13:0] rd_q;
   logic        vld_q;
   initial begin
      for (int i = 0; i < 128; i++) mem[i] = 14'h2000 | 14'(i);
      rd_q = 14'h0000;
      vld_q = 1'b0;
   end
   // Word held one cycle only; stale reads see garbage
   assign flash_rd_data = vld_q ? rd_q : ~rd_q;
   always @(posedge clock) begin
      vld_q <= flash_rd_en;
      if (flash_rd_en) rd_q <= mem[flash_addr[6:0]];
      if (flash_erase) begin
         for (int k = 0; k < 32; k++) mem[{flash_addr[6:5], 5'(k)}] <= 14'h3fff;
      end
      // Programming can only clear bits
      if (flash_prog_we) mem[flash_addr[6:0]] <= mem[flash_addr[6:0]] & flash_prog_data;
   end
endmodule

//--- tb/pfs_self_programmer_tb.sv
/*
 * Self-checking bench: core register strobes, flash array model, reads,
 * guarded erase, latch loads and block programming. Assumes 25 MHz clock.
 */
`timescale 1ns/1ps
module pfs_self_programmer_tb;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  core_wdata = 8'h00;
   logic [5:0]  strb = 6'h00;
   logic [7:0]  ah, al, dh, dl, ctl, ulk;
   logic        skip, stall, rd_en, erase, prog_we;
   logic [14:0] faddr;
   logic [13:0] rdata, pdata;
   int          error_cnt = 0;
   int          n_tests = 0;
   always #20 clock = ~clock;
   pfs_self_programmer #(.OP_CYCLES(8)) uut (
      .clock(clock), .rst(rst), .core_wdata(core_wdata), .addr_high_wr(strb[0]),
      .addr_low_wr(strb[1]), .data_high_wr(strb[2]), .data_low_wr(strb[3]),
      .control_wr(strb[4]), .unlock_wr(strb[5]), .nvm_address_high(ah), .nvm_address_low(al),
      .nvm_data_high(dh), .nvm_data_low(dl), .nvm_control(ctl), .nvm_unlock_register(ulk),
      .core_skip(skip), .core_stall(stall), .flash_rd_en(rd_en), .flash_addr(faddr),
      .flash_rd_data(rdata), .flash_erase(erase), .flash_prog_we(prog_we),
      .flash_prog_data(pdata));
   pfs_flash_model flash (
      .clock(clock), .flash_rd_en(rd_en), .flash_addr(faddr), .flash_rd_data(rdata),
      .flash_erase(erase), .flash_prog_we(prog_we), .flash_prog_data(pdata));
   // ----
   // Tasks
   // ----
   task automatic summarize();
      if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Strobe k: 0 addr hi, 1 addr lo, 2 data hi, 3 data lo, 4 control, 5 unlock
   task automatic wr(int k, logic [7:0] v);
      @(posedge clock);
      core_wdata <= v;
      strb <= 6'h01 << k;
      @(posedge clock);
      strb <= 6'h00;
   endtask
   // Bounded wait for both start bits to drop
   task automatic idle();
      for (int i = 0; i < 200; i++) begin
         @(posedge clock);
         #1;
         if (ctl[1:0] === 2'b00) return;
      end
      chk("idle_timeout", 16'h0001, 16'h0000);
      summarize();
   endtask
   task automatic rd(logic [14:0] a, logic [13:0] w);
      wr(0, 8'(a[14:8]));
      wr(1, a[7:0]);
      wr(4, 8'h80);
      wr(4, 8'h81);
      // No strobes while the read is in flight
      idle();
      chk("data_low", 16'(dl), 16'(w[7:0]));
      chk("data_high", 16'(dh), 16'(w[13:8]));
      chk("addr_low", 16'(al), 16'(a[7:0]));
      chk("addr_high", 16'(ah), 16'(a[14:8]));
   endtask
   task automatic op(logic [7:0] c, logic [7:0] u1, logic [7:0] u2, logic e);
      wr(5, u1);
      wr(5, u2);
      wr(4, c | 8'h02);
      #1;
      chk("write_start", 16'(ctl[1]), 16'(e));
      idle();
   endtask
   // ----
   // Sequence
   // ----
   initial begin
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      #1;
      chk("ctl_reset", 16'(ctl), 16'(pfs_pkg::CTL_RESET));
      chk("unlock_read", 16'(ulk), 16'h0000);
      rd(15'h0045, 14'h2045);
      wr(3, 8'h12);
      repeat (3) @(posedge clock);
      #1;
      chk("data_hold", 16'(dl), 16'h0012);
      wr(4, 8'hc0);
      wr(4, 8'hc1);
      #1;
      chk("cfg_read", 16'(ctl[0]), 16'h0000);
      wr(4, 8'h94);
      op(8'h94, 8'haa, 8'h55, 1'b0);
      wr(5, 8'h55);
      wr(5, 8'haa);
      op(8'h94, 8'h00, 8'h00, 1'b0);
      wr(5, 8'h55);
      wr(5, 8'haa);
      wr(4, 8'h94);
      wr(4, 8'h96);
      #1;
      chk("rearm", 16'(ctl[1]), 16'h0000);
      wr(4, 8'h90);
      op(8'h90, 8'h55, 8'haa, 1'b0);
      wr(4, 8'h94);
      op(8'h94, 8'h55, 8'haa, 1'b1);
      chk("erase_busy", 16'(ctl[4]), 16'h0000);
      rd(15'h0045, 14'h3fff);
      rd(15'h005f, 14'h3fff);
      rd(15'h003f, 14'h203f);
      rd(15'h0060, 14'h2060);
      wr(4, 8'ha4);
      for (int i = 0; i < 4; i++) begin
         if (i == 3) wr(4, 8'h84);
         wr(1, 8'h40 + 8'(i));
         wr(2, 8'h10 + 8'(i));
         wr(3, 8'h3c + 8'(i));
         op((i == 3) ? 8'h84 : 8'ha4, 8'h55, 8'haa, 1'b1);
      end
      for (int i = 0; i < 4; i++) begin
         rd(15'h0040 + 15'(i), {6'h10 + 6'(i), 8'h3c + 8'(i)});
      end
      rd(15'h0044, 14'h3fff);
      rd(15'h005f, 14'h3fff);
      rd(15'h0060, 14'h2060);
      wr(4, 8'h84);
      // Fresh block: stale latches from the last block would clear bits here
      wr(1, 8'h61);
      wr(2, 8'h0f);
      wr(3, 8'h0f);
      op(8'h84, 8'h55, 8'haa, 1'b1);
      rd(15'h0060, 14'h2060);
      rd(15'h0061, 14'h2061 & 14'h0f0f);
      summarize();
   end
endmodule
